// ---- logic/pfc_pkg.sv ----
package pfc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] A_CFG2 = 32'h2000_0504;
  localparam logic [31:0] A_CFG3 = 32'h2000_0508;
  localparam logic [31:0] A_CFG5 = 32'h2000_0510;
  localparam logic [31:0] A_SYNC0 = 32'h2000_0514;
  localparam logic [31:0] A_SYNC1 = 32'h2000_0518;
  localparam logic [31:0] A_POLY = 32'h2000_051c;
  localparam logic [31:0] A_SEED = 32'h2000_0520;
  localparam logic [31:0] A_FXOR = 32'h2000_0524;
  localparam logic [31:0] A_TICK = 32'h2000_052c;
  localparam logic [31:0] A_CTL = 32'h2000_0530;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int LC_LSB = 24;
  localparam int POL_BIT = 30;
  localparam logic [7:0] LC_MASK = 8'h0d;
  localparam logic [7:0] LC_MAN = 8'h04;
  localparam logic [7:0] LC_FEC = 8'h08;
  localparam int PRE_LSB = 16;
  localparam logic [7:0] PRE_DEFAULT = 8'h55;
  localparam int LEN_LSB = 12;
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h2;
  localparam int ZF_BIT = 11;
  localparam int S1_LSB = 3;
  localparam int PS_LSB = 4;
  localparam int PHR_FCS_BIT = 12;
  localparam int CTL_IEEE_BIT = 0;
  localparam int CTL_PSZ_LSB = 16;
  localparam logic [31:0] CTL_WMASK = 32'h0fff_0001;
  // ---------------------------------------------------------------
  // Bit counts, checksum defaults and tick source codes
  // ---------------------------------------------------------------
  localparam logic [5:0] PRE_BITS = 6'h20;
  localparam logic [5:0] SYNC_BITS = 6'h20;
  localparam logic [5:0] WIDE_BITS = 6'h20;
  localparam logic [5:0] NARROW_BITS = 6'h10;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [15:0] FCS32_BYTES = 16'h0004;
  localparam logic [15:0] FCS16_BYTES = 16'h0002;
  localparam logic [31:0] FCS16_POLY = 32'h0000_1021;
  localparam logic [31:0] FCS16_SEED = 32'h0000_0000;
  localparam logic [31:0] FCS32_POLY = 32'h04c1_1db7;
  localparam logic [31:0] FCS32_SEED = 32'hffff_ffff;
  localparam logic [3:0] TK_USER = 4'h1;
  localparam logic [3:0] TK_X2 = 4'h2;
  localparam logic [3:0] TK_X4 = 4'h3;
  localparam logic [3:0] TK_X8 = 4'h4;
  localparam logic [3:0] TK_X16 = 4'h5;
  localparam logic [3:0] TK_X32A = 4'h6;
  localparam logic [3:0] TK_X32B = 4'h7;
  localparam logic [3:0] TK_X32C = 4'h8;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CODE_NRZ, CODE_MAN, CODE_FEC} pfc_code_t;
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_SYNC, T_HDR, T_PAY, T_FL, T_CRC} pfc_tx_t;
  typedef enum logic [2:0] {R_HUNT, R_SYNC, R_HDR, R_PAY, R_CRC, R_FL} pfc_rx_t;
endpackage : pfc_pkg

// ---- logic/pfc_line_enc.sv ----
`timescale 1ns/1ps
module pfc_line_enc
  import pfc_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic clear_i, // Restart coder memory.
  input wire pfc_code_t code_i, // Selected line code.
  input wire logic invert_i, // Invert chips.
  input wire logic bit_i, // Bit to code.
  input wire logic bit_valid_i, // Bit offered.
  output logic bit_ready_o, // Bit taken.
  output logic chip_o, // Coded chip.
  output logic chip_valid_o // Chip strobe.
);
  typedef struct packed {
    logic hold;
    logic pend;
    logic [1:0] mem;
    logic chip;
    logic cv;
  } pfc_enc_t;
  pfc_enc_t st_r, st_nxt;

  assign bit_ready_o = ~st_r.hold;
  assign chip_o = st_r.chip;
  assign chip_valid_o = st_r.cv;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cv = 1'b0;
    if (clear_i) begin
      st_nxt.mem = 2'b00;
    end
    if (st_r.hold) begin
      st_nxt.chip = st_r.pend ^ invert_i; // R2
      st_nxt.cv = 1'b1;
      st_nxt.hold = 1'b0;
    end else if (bit_valid_i) begin
      st_nxt.cv = 1'b1;
      case (code_i) // R1
        CODE_MAN: begin
          st_nxt.chip = bit_i ^ invert_i;
          st_nxt.pend = ~bit_i;
          st_nxt.hold = 1'b1;
        end
        CODE_FEC: begin
          st_nxt.chip = bit_i ^ st_r.mem[0] ^ st_r.mem[1] ^ invert_i;
          st_nxt.pend = bit_i ^ st_r.mem[1];
          st_nxt.mem = {st_r.mem[0], bit_i};
          st_nxt.hold = 1'b1;
        end
        default: begin
          st_nxt.chip = bit_i ^ invert_i; // R2
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : pfc_line_enc

// ---- logic/pfc_crc.sv ----
`timescale 1ns/1ps
module pfc_crc
  import pfc_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic init_i, // Load seed, latch poly and width.
  input wire logic [31:0] seed_i, // Start value.
  input wire logic [31:0] poly_i, // Generator polynomial.
  input wire logic wide_i, // 32-bit when high, else 16-bit.
  input wire logic feed_i, // Shift one bit in.
  input wire logic bit_i, // Bit to shift in.
  output logic [31:0] crc_o // Running value.
);
  typedef struct packed {
    logic [31:0] crc;
    logic [31:0] poly;
    logic wide;
  } pfc_crc_t;
  pfc_crc_t st_r, st_nxt;
  logic fb;

  assign crc_o = st_r.crc;

  always_comb begin
    st_nxt = st_r;
    fb = bit_i ^ (st_r.wide ? st_r.crc[31] : st_r.crc[15]);
    if (init_i) begin
      st_nxt.crc = wide_i ? seed_i : {16'h0000, seed_i[15:0]};
      st_nxt.poly = poly_i;
      st_nxt.wide = wide_i;
    end else if (feed_i) begin
      st_nxt.crc = {st_r.crc[30:0], 1'b0} ^ (fb ? st_r.poly : 32'h0000_0000);
      if (!st_r.wide) begin
        st_nxt.crc[31:16] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : pfc_crc

// ---- logic/pfc_frame_top.sv ----
// Function
// [R1] Transmit applies one line code from a one-hot field: NRZ, Manchester or FEC.
// [R2] Polarity bit inverts over-the-air chips whatever code is selected.
// [R3] Preamble byte is sent on transmit and hunted for on receive.
// [R4] A zero preamble byte is replaced by 0x55.
// [R5] Length size code: 00 none, 01 eight bits, 10 sixteen bits.
// [R6] Host sets eight-bit length size for 802.15.4g receive.
// [R7] Zero-flush bit shifts CRC-length zeros into the CRC after the data.
// [R8] Six-bit field gives second sync word length, used only in 802.15.4g receive.
// [R9] Received length field, or 802.15.4g PHY header, is readable in bits 31:16.
// [R10] 802.15.4g transmit sends the configured PHY header as first two octets.
// [R11] First sync word serves generic frames and FEC 802.15.4g frames.
// [R12] Second sync word serves 802.15.4g frames without FEC.
// [R13] Polynomial register defines generic CRC and 802.15.4g transmit FCS.
// [R14] 802.15.4g receive takes FCS polynomial and seed from the received header.
// [R15] Seed register starts generic CRC and 802.15.4g transmit FCS.
// [R16] Final CRC is XORed with final-XOR value; zero result means valid.
// [R17] Tick source: user clock for 1, 2x to 32x rate for 2..6, 32x for 7, 8.
// [R18] Four-bit postscale stretches the tick period.
// [R19] Fixed-length receive takes payload byte count from the 12-bit size field.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module pfc_frame_top
  import pfc_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [31:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte enables.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Bus acknowledge.
  input wire logic tx_start_i, // Start a frame.
  input wire logic [15:0] tx_length_i, // Payload byte count.
  input wire logic [7:0] tx_byte_i, // Payload byte.
  input wire logic tx_byte_valid_i, // Payload byte offered.
  output logic tx_byte_ready_o, // Payload byte taken.
  output logic tx_busy_o, // Frame in progress.
  output logic tx_chip_o, // Coded chip to modem.
  output logic tx_chip_valid_o, // Chip strobe.
  input wire logic rx_bit_i, // Received bit.
  input wire logic rx_bit_valid_i, // Received bit strobe.
  input wire logic rx_abort_i, // Drop frame and hunt again.
  output logic [7:0] rx_byte_o, // Received payload byte.
  output logic rx_byte_valid_o, // Payload byte strobe.
  output logic rx_done_o, // Frame finished strobe.
  output logic rx_crc_ok_o, // Last frame checksum good.
  input wire logic user_tick_i, // Transmit user clock tick.
  input wire logic rate32_tick_i, // Tick at 32x data rate.
  output logic cca_tick_o // Channel assessment tick.
);
  typedef struct packed {
    logic [31:0] cfg2, cfg5, sync0, sync1, poly, seed, fxor, tick, ctl, rdat;
    logic ack;
    pfc_tx_t tst;
    logic [31:0] tsr;
    logic [5:0] tcnt;
    logic [15:0] tbytes;
    logic tfull;
    pfc_rx_t rxs;
    logic [31:0] rsr, rcrc;
    logic [5:0] rcnt;
    logic [15:0] rbytes, rlen;
    logic rok, rdone, rbv, rwide;
    logic [7:0] rbyte;
    logic [3:0] cdiv, cpost;
    logic ctick;
  } pfc_top_t;
  pfc_top_t st_r, st_nxt;

  logic [31:0] wmask;
  logic [7:0] pre;
  logic [1:0] lsel;
  logic ieee;
  pfc_code_t code;
  logic tx_wide, rx_wide_n;
  logic [31:0] sword, smask, tx_crc, rx_crc;
  logic enc_rdy;
  logic tx_bit_v, tx_init, tx_feed, tx_fbit, tx_last, go_pay, go_fl;
  logic rx_init, rx_feed, rx_fbit, go_rpay;
  logic [31:0] rsh;
  logic [15:0] rc, ln, fb;
  logic base;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_sel
    assign wmask[8*g+7:8*g] = {8{wb_sel_i[g]}};
  end

  assign pre = (st_r.cfg2[PRE_LSB+:8] == 8'h00) ? PRE_DEFAULT : st_r.cfg2[PRE_LSB+:8]; // R4
  assign lsel = st_r.cfg2[LEN_LSB+:2];
  assign ieee = st_r.ctl[CTL_IEEE_BIT];
  assign tx_wide = ieee ? ~st_r.cfg5[PHR_FCS_BIT] : 1'b1;
  assign rx_wide_n = ieee ? ~st_nxt.rlen[PHR_FCS_BIT] : 1'b1;

  always_comb begin
    case (st_r.cfg2[LC_LSB+:8] & LC_MASK) // R1
      LC_MAN: code = CODE_MAN;
      LC_FEC: code = CODE_FEC;
      default: code = CODE_NRZ;
    endcase
  end

  assign sword = (ieee && code != CODE_FEC) ? st_r.sync1 : st_r.sync0; // R11 R12
  assign smask = (!ieee || code == CODE_FEC || st_r.cfg2[S1_LSB+:6] == 6'h00) ? 32'hffff_ffff :
                 ~(32'hffff_ffff << st_r.cfg2[S1_LSB+:6]); // R8

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    tx_init = 1'b0;
    tx_feed = 1'b0;
    tx_fbit = st_r.tsr[31];
    go_pay = 1'b0;
    go_fl = 1'b0;
    rx_init = 1'b0;
    rx_feed = 1'b0;
    rx_fbit = rx_bit_i;
    go_rpay = 1'b0;
    rc = 16'h0000;
    ln = {5'h00, st_r.rlen[10:0]};
    fb = FCS32_BYTES;
    base = 1'b0;
    rsh = {st_r.rsr[30:0], rx_bit_i};
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.rbv = 1'b0;
    st_nxt.rdone = 1'b0;
    st_nxt.ctick = 1'b0;

    // Register writes and read data capture.
    if (st_nxt.ack && wb_we_i) begin
      case (wb_adr_i)
        A_CFG2: st_nxt.cfg2 = (st_r.cfg2 & ~wmask) | (wb_dat_i & wmask);
        A_CFG5: st_nxt.cfg5 = (st_r.cfg5 & ~wmask) | (wb_dat_i & wmask);
        A_SYNC0: st_nxt.sync0 = (st_r.sync0 & ~wmask) | (wb_dat_i & wmask);
        A_SYNC1: st_nxt.sync1 = (st_r.sync1 & ~wmask) | (wb_dat_i & wmask);
        A_POLY: st_nxt.poly = (st_r.poly & ~wmask) | (wb_dat_i & wmask);
        A_SEED: st_nxt.seed = (st_r.seed & ~wmask) | (wb_dat_i & wmask);
        A_FXOR: st_nxt.fxor = (st_r.fxor & ~wmask) | (wb_dat_i & wmask);
        A_TICK: st_nxt.tick = (st_r.tick & ~wmask) | (wb_dat_i & wmask);
        A_CTL: st_nxt.ctl = ((st_r.ctl & ~wmask) | (wb_dat_i & wmask)) & CTL_WMASK;
        default: st_nxt.ctl = st_r.ctl;
      endcase
    end
    if (st_nxt.ack && !wb_we_i) begin
      case (wb_adr_i)
        A_CFG2: st_nxt.rdat = st_r.cfg2;
        A_CFG3: st_nxt.rdat = {st_r.rlen, 16'h0000}; // R9
        A_CFG5: st_nxt.rdat = st_r.cfg5;
        A_SYNC0: st_nxt.rdat = st_r.sync0;
        A_SYNC1: st_nxt.rdat = st_r.sync1;
        A_POLY: st_nxt.rdat = st_r.poly;
        A_SEED: st_nxt.rdat = st_r.seed;
        A_FXOR: st_nxt.rdat = st_r.fxor;
        A_TICK: st_nxt.rdat = st_r.tick;
        A_CTL: st_nxt.rdat = st_r.ctl | {st_r.rok, st_r.tst != T_IDLE, st_r.rxs != R_HUNT, 29'h0};
        default: st_nxt.rdat = RST_WORD;
      endcase
    end

    // Transmit sequencer.
    tx_bit_v = (st_r.tst == T_PRE) || (st_r.tst == T_SYNC) || (st_r.tst == T_HDR) ||
               (st_r.tst == T_CRC) || (st_r.tst == T_PAY && st_r.tfull);
    tx_last = tx_bit_v && enc_rdy && (st_r.tcnt == 6'h01);
    if (tx_bit_v && enc_rdy) begin
      st_nxt.tsr = {st_r.tsr[30:0], 1'b0};
      st_nxt.tcnt = st_r.tcnt - 6'h01;
    end
    case (st_r.tst)
      T_IDLE: begin
        if (tx_start_i) begin
          st_nxt.tst = T_PRE;
          st_nxt.tsr = {4{pre}}; // R3
          st_nxt.tcnt = PRE_BITS;
          st_nxt.tbytes = (!ieee && lsel == LEN_FIXED) ? {4'h0, st_r.ctl[CTL_PSZ_LSB+:12]} :
                          tx_length_i;
          tx_init = 1'b1; // R13 R15
        end
      end
      T_PRE: begin
        if (tx_last) begin
          st_nxt.tst = T_SYNC;
          st_nxt.tsr = sword; // R11 R12
          st_nxt.tcnt = SYNC_BITS;
        end
      end
      T_SYNC: begin
        if (tx_last) begin
          st_nxt.tst = T_HDR;
          if (ieee) begin
            st_nxt.tsr = {st_r.cfg5[15:0], 16'h0000}; // R10
            st_nxt.tcnt = NARROW_BITS;
          end else begin
            case (lsel) // R5
              LEN_8: begin
                st_nxt.tsr = {st_r.tbytes[7:0], 24'h000000};
                st_nxt.tcnt = BYTE_BITS;
              end
              LEN_16: begin
                st_nxt.tsr = {st_r.tbytes, 16'h0000};
                st_nxt.tcnt = NARROW_BITS;
              end
              default: go_pay = 1'b1;
            endcase
          end
        end
      end
      T_HDR: begin
        go_pay = tx_last;
      end
      T_PAY: begin
        tx_feed = tx_bit_v && enc_rdy;
        if (!st_r.tfull && tx_byte_valid_i) begin
          st_nxt.tsr = {tx_byte_i, 24'h000000};
          st_nxt.tcnt = BYTE_BITS;
          st_nxt.tfull = 1'b1;
        end
        if (tx_last) begin
          st_nxt.tfull = 1'b0;
          st_nxt.tbytes = st_r.tbytes - 16'h0001;
          go_fl = (st_r.tbytes == 16'h0001);
        end
      end
      T_FL: begin
        if (st_r.tcnt != 6'h00) begin
          tx_feed = 1'b1; // R7
          tx_fbit = 1'b0;
          st_nxt.tcnt = st_r.tcnt - 6'h01;
        end else begin
          st_nxt.tst = T_CRC;
          st_nxt.tsr = tx_wide ? (tx_crc ^ st_r.fxor) :
                       {tx_crc[15:0] ^ st_r.fxor[15:0], 16'h0000}; // R16
          st_nxt.tcnt = tx_wide ? WIDE_BITS : NARROW_BITS;
        end
      end
      T_CRC: begin
        if (tx_last) begin
          st_nxt.tst = T_IDLE;
        end
      end
      default: st_nxt.tst = T_IDLE;
    endcase
    if (go_pay) begin
      st_nxt.tfull = 1'b0;
      if (st_r.tbytes == 16'h0000) begin
        go_fl = 1'b1;
      end else begin
        st_nxt.tst = T_PAY;
      end
    end
    if (go_fl) begin
      st_nxt.tst = T_FL;
      st_nxt.tcnt = st_r.cfg2[ZF_BIT] ? (tx_wide ? WIDE_BITS : NARROW_BITS) : 6'h00; // R7
    end

    // Receive sequencer.
    case (st_r.rxs)
      R_HUNT: begin
        if (rx_bit_valid_i) begin
          st_nxt.rsr = rsh;
          if (rsh[7:0] == pre) begin // R3
            st_nxt.rxs = R_SYNC;
          end
        end
      end
      R_SYNC: begin
        if (rx_bit_valid_i) begin
          st_nxt.rsr = rsh;
          if (((rsh ^ sword) & smask) == 32'h0000_0000) begin // R8 R11 R12
            st_nxt.rxs = R_HDR;
            st_nxt.rcnt = NARROW_BITS;
            if (!ieee) begin
              case (lsel) // R5
                LEN_8: st_nxt.rcnt = BYTE_BITS;
                LEN_16: st_nxt.rcnt = NARROW_BITS;
                default: go_rpay = 1'b1;
              endcase
            end
          end
        end
      end
      R_HDR: begin
        if (rx_bit_valid_i) begin
          st_nxt.rsr = rsh;
          st_nxt.rcnt = st_r.rcnt - 6'h01;
          if (st_r.rcnt == 6'h01) begin
            st_nxt.rlen = (!ieee && lsel == LEN_8) ? {8'h00, rsh[7:0]} : rsh[15:0]; // R9
            go_rpay = 1'b1;
          end
        end
      end
      R_PAY: begin
        if (rx_bit_valid_i) begin
          st_nxt.rsr = rsh;
          rx_feed = 1'b1;
          st_nxt.rcnt = st_r.rcnt - 6'h01;
          if (st_r.rcnt == 6'h01) begin
            st_nxt.rbyte = rsh[7:0];
            st_nxt.rbv = 1'b1;
            st_nxt.rcnt = BYTE_BITS;
            st_nxt.rbytes = st_r.rbytes - 16'h0001;
            if (st_r.rbytes == 16'h0001) begin
              st_nxt.rxs = R_CRC;
              st_nxt.rcnt = st_r.rwide ? WIDE_BITS : NARROW_BITS;
            end
          end
        end
      end
      R_CRC: begin
        if (rx_bit_valid_i) begin
          st_nxt.rcrc = {st_r.rcrc[30:0], rx_bit_i};
          st_nxt.rcnt = st_r.rcnt - 6'h01;
          if (st_r.rcnt == 6'h01) begin
            st_nxt.rxs = R_FL;
            st_nxt.rcnt = st_r.cfg2[ZF_BIT] ? (st_r.rwide ? WIDE_BITS : NARROW_BITS) :
                          6'h00; // R7
          end
        end
      end
      R_FL: begin
        if (st_r.rcnt != 6'h00) begin
          rx_feed = 1'b1; // R7
          rx_fbit = 1'b0;
          st_nxt.rcnt = st_r.rcnt - 6'h01;
        end else begin
          st_nxt.rok = (((rx_crc ^ st_r.fxor ^ st_r.rcrc) &
                        (st_r.rwide ? 32'hffff_ffff : 32'h0000_ffff)) == 32'h0000_0000); // R16
          st_nxt.rdone = 1'b1;
          st_nxt.rxs = R_HUNT;
        end
      end
      default: st_nxt.rxs = R_HUNT;
    endcase
    if (go_rpay) begin
      rx_init = 1'b1;
      st_nxt.rwide = rx_wide_n;
      st_nxt.rcrc = 32'h0000_0000;
      ln = {5'h00, st_nxt.rlen[10:0]};
      fb = rx_wide_n ? FCS32_BYTES : FCS16_BYTES;
      if (ieee) begin
        rc = (ln > fb) ? ln - fb : 16'h0000;
      end else if (lsel == LEN_FIXED) begin
        rc = {4'h0, st_r.ctl[CTL_PSZ_LSB+:12]}; // R19
      end else begin
        rc = st_nxt.rlen;
      end
      st_nxt.rbytes = rc;
      st_nxt.rcnt = BYTE_BITS;
      st_nxt.rxs = R_PAY;
      if (rc == 16'h0000) begin
        st_nxt.rxs = R_CRC;
        st_nxt.rcnt = rx_wide_n ? WIDE_BITS : NARROW_BITS;
      end
    end
    if (rx_abort_i) begin
      st_nxt.rxs = R_HUNT;
    end

    // Channel assessment tick.
    if (rate32_tick_i) begin
      st_nxt.cdiv = st_r.cdiv + 4'h1;
    end
    case (st_r.tick[3:0]) // R17
      TK_USER: base = user_tick_i;
      TK_X2: base = rate32_tick_i && (st_r.cdiv == 4'hf);
      TK_X4: base = rate32_tick_i && (st_r.cdiv[2:0] == 3'h7);
      TK_X8: base = rate32_tick_i && (st_r.cdiv[1:0] == 2'h3);
      TK_X16: base = rate32_tick_i && st_r.cdiv[0];
      TK_X32A, TK_X32B, TK_X32C: base = rate32_tick_i;
      default: base = 1'b0;
    endcase
    if (base) begin
      if (st_r.cpost == st_r.tick[PS_LSB+:4]) begin // R18
        st_nxt.ctick = 1'b1;
        st_nxt.cpost = 4'h0;
      end else begin
        st_nxt.cpost = st_r.cpost + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checksums and line coder
  // ---------------------------------------------------------------
  pfc_crc u_tx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(tx_init),
    .seed_i(st_r.seed), // R15
    .poly_i(st_r.poly), // R13
    .wide_i(tx_wide),
    .feed_i(tx_feed),
    .bit_i(tx_fbit),
    .crc_o(tx_crc)
  );

  pfc_crc u_rx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(rx_init),
    .seed_i(ieee ? (rx_wide_n ? FCS32_SEED : FCS16_SEED) : st_r.seed), // R14 R15
    .poly_i(ieee ? (rx_wide_n ? FCS32_POLY : FCS16_POLY) : st_r.poly), // R14 R13
    .wide_i(rx_wide_n),
    .feed_i(rx_feed),
    .bit_i(rx_fbit),
    .crc_o(rx_crc)
  );

  pfc_line_enc u_enc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(tx_init),
    .code_i(code),
    .invert_i(st_r.cfg2[POL_BIT]), // R2
    .bit_i(st_r.tsr[31]),
    .bit_valid_i(tx_bit_v),
    .bit_ready_o(enc_rdy),
    .chip_o(tx_chip_o),
    .chip_valid_o(tx_chip_valid_o)
  );

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign tx_byte_ready_o = (st_r.tst == T_PAY) && !st_r.tfull;
  assign tx_busy_o = (st_r.tst != T_IDLE);
  assign rx_byte_o = st_r.rbyte;
  assign rx_byte_valid_o = st_r.rbv;
  assign rx_done_o = st_r.rdone;
  assign rx_crc_ok_o = st_r.rok;
  assign cca_tick_o = st_r.ctick;
endmodule : pfc_frame_top

// ---- dv/pfc_checker.sv ----
`timescale 1ns/1ps
module pfc_checker (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_ack_o, // Ack.
  input wire logic tx_start_i, // Start.
  input wire logic tx_busy_o, // Busy.
  input wire logic tx_byte_ready_o, // Ready.
  input wire logic rx_bit_valid_i, // Bit.
  input wire logic rx_byte_valid_o, // Byte.
  input wire logic rx_done_o, // Done.
  input wire logic user_tick_i, // Tick.
  input wire logic rate32_tick_i, // Tick.
  input wire logic cca_tick_o // Tick out.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  AST_WB_ACK: assert property (s_req |=> s_ack) else $error("bad ack");
  AST_WB_IDLE: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o) else $error("stray");
  AST_TX_TAKE: assert property (tx_start_i && !tx_busy_o |=> tx_busy_o) else $error("lost");
  AST_TX_READY: assert property (tx_byte_ready_o |-> tx_busy_o) else $error("idle");
  AST_RX_BYTE: assert property ($rose(rx_byte_valid_o) |-> $past(rx_bit_valid_i))
    else $error("byte");
  AST_RX_DONE: assert property (rx_done_o |=> !rx_done_o) else $error("done");
  AST_CCA_ONE: assert property (!user_tick_i && !rate32_tick_i |=> !cca_tick_o)
    else $error("tick");
  AST_CCA_SRC: assert property (cca_tick_o |-> $past(user_tick_i) || $past(rate32_tick_i))
    else $error("src");
endmodule : pfc_checker

// ---- dv/pfc_modem_model.sv ----
`timescale 1ns/1ps
module pfc_modem_model (
  input wire logic clk_i, // Clock.
  input wire logic clr_i, // Frame start.
  input wire logic loop_i, // Feed back.
  input wire logic chip_i, // Chip.
  input wire logic chip_valid_i, // Strobe.
  output logic rx_bit_o, // Bit.
  output logic rx_bit_valid_o, // Strobe.
  output logic [31:0] head_o // First chips.
);
  logic [5:0] n_r = '0;
  // An idle line toggles so a stale level never reads as data.
  always @(posedge clk_i) begin
    rx_bit_valid_o <= loop_i && chip_valid_i === 1'b1;
    rx_bit_o <= chip_valid_i ? chip_i : ~rx_bit_o;
    if (clr_i) n_r <= '0;
    else if (chip_valid_i === 1'b1 && n_r < 6'h20) begin
      head_o <= {head_o[30:0], chip_i};
      n_r <= n_r + 6'h01;
    end
  end
endmodule : pfc_modem_model

// ---- dv/tb_pfc_frame_top.sv ----
`timescale 1ns/1ps
module tb_pfc_frame_top;
  import pfc_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, tx_start_i = 0;
  logic tx_byte_valid_i = 1, rx_abort_i = 0, user_tick_i = 0, rate32_tick_i = 0, loop = 0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd, v, lf = 32'h12a0, head, ticks;
  logic [31:0] fails = 0, n_compared = 0;
  logic [3:0] wb_sel_i = 4'hf, bk = '0;
  logic [15:0] tx_length_i = '0;
  logic [7:0] tx_byte_i, rx_byte_o, p, pay[16], got[16];
  logic [1:0] ln;
  logic wb_ack_o, tx_byte_ready_o, tx_busy_o, tx_chip_o, tx_chip_valid_o, rx_bit_i, dn, ok;
  logic rx_bit_valid_i, rx_byte_valid_o, rx_done_o, rx_crc_ok_o, cca_tick_o;
  int rk, nb;
  logic [31:0] regs[8] = '{A_CFG2, A_CFG5, A_SYNC0, A_SYNC1, A_POLY, A_SEED, A_FXOR, A_TICK};
  pfc_frame_top u_pfc_frame_top (.*);
  pfc_modem_model u_pfc_modem_model (.clk_i, .clr_i(tx_start_i), .loop_i(loop),
    .chip_i(tx_chip_o), .chip_valid_i(tx_chip_valid_o), .rx_bit_o(rx_bit_i),
    .rx_bit_valid_o(rx_bit_valid_i), .head_o(head));
  assign tx_byte_i = pay[bk];
  always #2 clk_i = ~clk_i;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [31:0] tk_exp(input int c);
    return (c == 0) ? 0 : 64 / ((c >= 2 && c <= 5) ? 2 << (6 - c) : 2);
  endfunction : tk_exp
  function automatic logic [31:0] mc(input logic [15:0] b);
    for (int i = 0; i < 16; i++) mc[2*i+:2] = {b[i], ~b[i]};
  endfunction : mc
  always @(posedge clk_i) begin
    if (tx_start_i) bk <= '0;
    else if (tx_byte_ready_o === 1'b1) bk <= bk + 4'h1;
    if (rx_byte_valid_o === 1'b1) begin got[rk[3:0]] <= rx_byte_o; rk <= rk + 1; end
    if (rx_done_o === 1'b1) begin dn <= 1; ok <= rx_crc_ok_o; end
    if (cca_tick_o === 1'b1) ticks <= ticks + 1;
  end
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask : chk
  task automatic wb(input logic w, input logic [31:0] a, d);
    int t;
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    t = 0;
    do begin @(posedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 20);
    chk(t < 20, 1);
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic frame(input logic lp);
    int t;
    rk = 0; dn = 0; loop <= lp; tx_length_i <= 16'(nb); tx_start_i <= 1;
    @(posedge clk_i);
    tx_start_i <= 0; t = 0;
    do begin @(posedge clk_i); t++; end while ((tx_busy_o !== 0 || (lp && !dn)) && t < 3000);
    chk(t < 3000, 1);
    rx_abort_i <= 1; loop <= 0;
    @(posedge clk_i);
    rx_abort_i <= 0;
  endtask : frame
  task automatic results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin #200000; fails++; $display("ERROR %0t hang", $time); results(); end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, A_CFG3, 0); chk(rd, RST_WORD);
    foreach (regs[i]) begin
      wb(0, regs[i], 0); chk(rd, RST_WORD);
      lf = nx(lf); v = lf; wb(1, regs[i], v); wb(0, regs[i], 0); chk(rd, v);
    end
    wb(1, A_CFG3, lf); wb(0, A_CFG3, 0); chk(rd, RST_WORD);
    wb(1, 32'h2000_0528, lf); wb(0, 32'h2000_0528, 0); chk(rd, RST_WORD);
    wb(1, A_POLY, FCS32_POLY);
    $display("test regs done");
    for (int c = 0; c < 5; c++) begin
      lf = nx(lf); nb = 1 + lf[2:0]; p = (c == 0) ? 8'h00 : lf[15:8] | 8'h01;
      ln = (c == 1) ? LEN_FIXED : (c == 2) ? LEN_16 : LEN_8;
      for (int i = 0; i < 16; i++) begin lf = nx(lf); pay[i] = lf[7:0]; end
      wb(1, A_CTL, {4'h0, 12'(nb), 15'h0, c == 4});
      wb(1, A_CFG2, {(c == 3) ? 8'h44 : 8'h01, p, 2'b00, ln, lf[20], 11'h0});
      if (c == 4) begin wb(1, A_SEED, FCS32_SEED); wb(1, A_CFG5, nb + 4); end
      frame(c != 3);
      chk(head, (c == 3) ? ~mc({2{p}}) : {4{(p == 0) ? PRE_DEFAULT : p}});
      if (c != 3) begin
        chk(rk, nb);
        for (int i = 0; i < nb; i++) chk(got[i], pay[i]);
        chk(ok, 1);
        wb(0, A_CFG3, 0);
        if (ln != LEN_FIXED) chk(rd[31:16], nb + 4 * (c == 4));
      end
    end
    $display("test frames done");
    for (int c = 0; c < 9; c++) begin
      wb(1, A_TICK, 32'(c) | 32'h10);
      ticks = 0;
      repeat (64) begin
        user_tick_i <= 1; rate32_tick_i <= 1; @(posedge clk_i);
        user_tick_i <= 0; rate32_tick_i <= 0; @(posedge clk_i);
      end
      repeat (2) @(posedge clk_i);
      v = tk_exp(c);
      chk(ticks + 1 - v <= 2, 1);
    end
    $display("test tick done");
    results();
  end
endmodule : tb_pfc_frame_top
bind pfc_frame_top pfc_checker u_pfc_checker (.*);
